/* bench/pcd_mgr_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// port manager model: single-byte register accesses over the host port
module pcd_mgr_model
    import pcd_pkg::*;
(
    // clock
    input  wire logic       clk,
    // register access toward the decoder
    output var pcd_reg_req_t reg_req,
    input  wire logic [7:0] reg_rdata_r
);
    initial begin
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
    end

    // one byte per write, so each command byte acts once
    // released fields carry inverted junk, not the last value
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        reg_req.wr    = 1'b1;
        reg_req.addr  = a;
        reg_req.wdata = d;
        @(posedge clk);
        #1;
        reg_req.wr    = 1'b0;
        reg_req.addr  = ~a;
        reg_req.wdata = ~d;
    endtask

    // read data lands one edge after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        reg_req.rd   = 1'b1;
        reg_req.addr = a;
        @(posedge clk);
        #1;
        reg_req.rd   = 1'b0;
        reg_req.addr = ~a;
        @(posedge clk);
        #1;
        d = reg_rdata_r;
    endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcd_map.svh"
module tb;
    import pcd_pkg::*;
    // ==========================================================================
    // signals
    logic         clk, srst, vconn_overcurrent_flag_pin, vbus_above_pin, invalid_conn_reached;
    logic         sink_tx_req, goodcrc_sent, bus_power_present_r, toggle_start_r;
    logic         toggle_start_rd_r, rx_final_armed_r, rx_detect_clear_r;
    logic         host_if_idle_r, host_if_wake_r, exp_err, exp_idle, exp_arm;
    logic [7:0]   reg_rdata_r, outgoing_byte_count, fault_status_r, rd_v;
    pcd_reg_req_t reg_req;
    pcd_role_t    role;
    pcd_power_t   power_r, exp_pwr;
    int           n_fail, num_checks;
    logic [7:0]   codes [15] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88,
                                 8'h99, 8'hAA, 8'hCC, 8'hDD, 8'hEE, 8'hFF, 8'h5A};
    pcd_role_t    roles [4] = '{5'b1_01_01, 5'b1_10_10, 5'b0_01_01, 5'b1_01_10};

    pcd_top #(.ADDR_W(8), .SRC_HV_CAPABLE(1'b1)) i_pcd_top (
        .clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
        .vconn_overcurrent_flag_pin(vconn_overcurrent_flag_pin), .vbus_above_pin(vbus_above_pin), .role(role),
        .invalid_conn_reached(invalid_conn_reached), .sink_tx_req(sink_tx_req),
        .outgoing_byte_count(outgoing_byte_count), .goodcrc_sent(goodcrc_sent),
        .power_r(power_r), .bus_power_present_r(bus_power_present_r),
        .toggle_start_r(toggle_start_r), .toggle_start_rd_r(toggle_start_rd_r),
        .rx_final_armed_r(rx_final_armed_r), .rx_detect_clear_r(rx_detect_clear_r),
        .host_if_idle_r(host_if_idle_r), .host_if_wake_r(host_if_wake_r),
        .fault_status_r(fault_status_r));
    pcd_mgr_model i_pcd_mgr_model (.clk(clk), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r));

    // ==========================================================================
    // helpers
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // refusals leave the path enables untouched and only flag the error
    function automatic pcd_power_t exp_power(input logic [7:0] c, input pcd_power_t p,
                                             output logic err);
        pcd_power_t n;
        n   = p;
        err = 1'b0;
        case (c)
            `PCD_CMD_PRESENCE_OFF: begin
                err = p.src_en | p.snk_en;
                if (!err) n.det_en = 1'b0;
            end
            `PCD_CMD_PRESENCE_ON:  n.det_en = 1'b1;
            `PCD_CMD_SINK_OFF:     n.snk_en = 1'b0;
            `PCD_CMD_SINK_ON: begin
                err = p.src_en;
                if (!err) n = '{src_en: 1'b0, src_hv: 1'b0, snk_en: 1'b1, det_en: 1'b1};
            end
            `PCD_CMD_SOURCE_OFF: begin
                n.src_en = 1'b0;
                n.src_hv = 1'b0;
            end
            `PCD_CMD_SOURCE_5V: begin
                err = p.snk_en;
                if (!err) n = '{src_en: 1'b1, src_hv: 1'b0, snk_en: 1'b0, det_en: 1'b1};
            end
            `PCD_CMD_SOURCE_RAISED: begin
                err = !p.src_en | p.snk_en;
                if (!err) n.src_hv = 1'b1;
            end
            default: ;
        endcase
        return n;
    endfunction

    task automatic run_cmd(input logic [7:0] c, input pcd_role_t r);
        logic e;
        logic tog;
        role    = r;
        exp_pwr = exp_power(c, exp_pwr, e);
        exp_err = exp_err | e;
        tog     = (c == `PCD_CMD_CONN_SEARCH) && r.drp && (r.cc1 == r.cc2)
                  && (r.cc1 == `PCD_CC_RP || r.cc1 == `PCD_CC_RD);
        if (c == `PCD_CMD_HOST_IF_IDLE) exp_idle = 1'b1;
        if (c == `PCD_CMD_WAKE_HOST_IF) exp_idle = 1'b0;
        if (c == `PCD_CMD_RX_FINAL) exp_arm = 1'b1;
        i_pcd_mgr_model.write_reg(`PCD_COMMAND_ENTRY_OFFSET, c);
        // effects land one edge after the internal valid pulse; pulses stand one cycle
        @(posedge clk);
        #1;
        check("power", {4'h0, power_r}, {4'h0, exp_pwr});
        check("err_bit", {7'h00, fault_status_r[0]}, {7'h00, exp_err});
        check("idle", {7'h00, host_if_idle_r}, {7'h00, exp_idle});
        check("wake", {7'h00, host_if_wake_r}, {7'h00, c == `PCD_CMD_WAKE_HOST_IF});
        check("toggle", {7'h00, toggle_start_r}, {7'h00, tog});
        if (tog) check("toggle_rd", {7'h00, toggle_start_rd_r}, {7'h00, r.cc1 == `PCD_CC_RD});
        check("armed", {7'h00, rx_final_armed_r}, {7'h00, exp_arm});
        if (exp_err) begin
            i_pcd_mgr_model.write_reg(`PCD_FAULT_STATUS_OFFSET, 8'h01);
            @(posedge clk);
            #1;
            exp_err = 1'b0;
            check("err_clear", {7'h00, fault_status_r[0]}, 8'h00);
        end
    endtask

    task automatic err_event(input logic inv, input logic [7:0] cnt, input logic e);
        invalid_conn_reached = inv;
        sink_tx_req          = ~inv;
        outgoing_byte_count  = cnt;
        @(posedge clk);
        #1;
        invalid_conn_reached = 1'b0;
        sink_tx_req          = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("err_event", {7'h00, fault_status_r[0]}, {7'h00, e});
        i_pcd_mgr_model.write_reg(`PCD_FAULT_STATUS_OFFSET, 8'h01);
        @(posedge clk);
        #1;
    endtask

    // ==========================================================================
    // clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    initial begin
        {srst, vconn_overcurrent_flag_pin, vbus_above_pin, invalid_conn_reached} = 4'h1 << 3;
        {sink_tx_req, goodcrc_sent, outgoing_byte_count} = '0;
        role = '0;
        {n_fail, num_checks} = '0;
        {exp_pwr, exp_err, exp_idle, exp_arm} = '0;
        void'($urandom(32'h0000_bf20));
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b0;
        check("fault_rst", fault_status_r, `PCD_FAULT_STATUS_RESET);
        i_pcd_mgr_model.read_reg(`PCD_COMMAND_ENTRY_OFFSET, rd_v);
        check("cmd_rst", rd_v, `PCD_COMMAND_ENTRY_RESET);
        i_pcd_mgr_model.read_reg(8'h40, rd_v);
        check("unmapped", rd_v, 8'h00);
        i_pcd_mgr_model.write_reg(`PCD_FAULT_STATUS_OFFSET, 8'h00);
        // let an edge pass so the address is not driven twice in one step
        @(posedge clk);
        #1;
        i_pcd_mgr_model.read_reg(`PCD_FAULT_STATUS_OFFSET, rd_v);
        check("w0_keeps", rd_v, 8'h80);
        i_pcd_mgr_model.write_reg(`PCD_FAULT_STATUS_OFFSET, 8'h80);
        @(posedge clk);
        #1;
        check("w1_clears", fault_status_r, 8'h00);
        $display("test registers done");
        foreach (codes[i]) run_cmd(codes[i], '0);
        i_pcd_mgr_model.read_reg(`PCD_COMMAND_ENTRY_OFFSET, rd_v);
        check("cmd_autoclr", rd_v, 8'h00);
        // same role written twice: search must restart each time
        foreach (roles[i]) repeat (2) run_cmd(`PCD_CMD_CONN_SEARCH, roles[i]);
        repeat (60) run_cmd(codes[$urandom_range(14, 0)], pcd_role_t'(5'($urandom_range(31, 0))));
        $display("test commands done");
        err_event(1'b0, 8'($urandom_range(1, 0)), 1'b1);
        err_event(1'b0, 8'($urandom_range(255, 2)), 1'b0);
        err_event(1'b1, 8'h00, 1'b1);
        vconn_overcurrent_flag_pin = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        vconn_overcurrent_flag_pin = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check("ocp_latched", fault_status_r, 8'h02);
        i_pcd_mgr_model.write_reg(`PCD_FAULT_STATUS_OFFSET, 8'h02);
        @(posedge clk);
        #1;
        check("ocp_clear", fault_status_r, 8'h00);
        $display("test faults done");
        run_cmd(`PCD_CMD_PRESENCE_ON, '0);
        vbus_above_pin = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check("vbus_on", {7'h00, bus_power_present_r}, 8'h01);
        run_cmd(`PCD_CMD_SOURCE_OFF, '0);
        run_cmd(`PCD_CMD_SINK_OFF, '0);
        check("vbus_kept", {7'h00, bus_power_present_r}, 8'h01);
        run_cmd(`PCD_CMD_PRESENCE_OFF, '0);
        // presence flag is registered behind the detection enable
        @(posedge clk);
        #1;
        check("vbus_off", {7'h00, bus_power_present_r}, 8'h00);
        vbus_above_pin = 1'b0;
        $display("test presence done");
        run_cmd(`PCD_CMD_RX_FINAL, '0);
        goodcrc_sent = 1'b1;
        @(posedge clk);
        #1;
        goodcrc_sent = 1'b0;
        exp_arm      = 1'b0;
        check("rx_clear", {7'h00, rx_detect_clear_r}, 8'h01);
        check("rx_disarm", {7'h00, rx_final_armed_r}, 8'h00);
        @(posedge clk);
        #1;
        check("rx_pulse", {7'h00, rx_detect_clear_r}, 8'h00);
        $display("test receive done");
        finish_test();
    end
endmodule
`default_nettype wire

/* verilog/pcd_cmd_reg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcd_map.svh"

module pcd_cmd_reg (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // host write
    input  wire logic       wr_stb,
    input  wire logic [7:0] wdata,
    // command out
    output logic      [7:0] cmd_byte_r,
    output logic            cmd_valid_r
);

    // ======================================================================
    // command holding register
    // a new write in the clear cycle wins so no command is lost
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_byte_r <= `PCD_COMMAND_ENTRY_RESET;
        end else if (wr_stb) begin
            cmd_byte_r <= wdata;
        end else if (cmd_valid_r) begin
            cmd_byte_r <= `PCD_COMMAND_ENTRY_RESET;
        end
    end

    // one pulse per completed write, so a byte acts only once
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_valid_r <= 1'b0;
        end else begin
            cmd_valid_r <= wr_stb;
        end
    end

endmodule
`default_nettype wire

/* verilog/pcd_map.svh */
`ifndef PCD_MAP_SVH
`define PCD_MAP_SVH

// ==========================================================================
// register offsets
`define PCD_FAULT_STATUS_OFFSET   8'h1F
`define PCD_COMMAND_ENTRY_OFFSET  8'h23

// ==========================================================================
// reset values
`define PCD_FAULT_STATUS_RESET    8'h80
`define PCD_COMMAND_ENTRY_RESET   8'h00

// ==========================================================================
// fault status field positions
`define PCD_FLT_ALL_REGS_RESET_BIT 7
`define PCD_FLT_VCONN_OVERCURRENT_FLAG_BIT      1
`define PCD_FLT_HOST_BUS_ERR_BIT   0

// ==========================================================================
// command codes
`define PCD_CMD_WAKE_HOST_IF      8'h11
`define PCD_CMD_PRESENCE_OFF      8'h22
`define PCD_CMD_PRESENCE_ON       8'h33
`define PCD_CMD_SINK_OFF          8'h44
`define PCD_CMD_SINK_ON           8'h55
`define PCD_CMD_SOURCE_OFF        8'h66
`define PCD_CMD_SOURCE_5V         8'h77
`define PCD_CMD_SOURCE_RAISED     8'h88
`define PCD_CMD_CONN_SEARCH       8'h99
`define PCD_CMD_RX_FINAL          8'hAA
`define PCD_CMD_RESERVED_C        8'hCC
`define PCD_CMD_RESERVED_D        8'hDD
`define PCD_CMD_RESERVED_E        8'hEE
`define PCD_CMD_HOST_IF_IDLE      8'hFF

// ==========================================================================
// role field codes and transmit limits
`define PCD_CC_RP                 2'h1
`define PCD_CC_RD                 2'h2
`define PCD_TX_MIN_BYTES          8'h02

`endif

/* verilog/pcd_pkg.sv */
`default_nettype none
package pcd_pkg;

    // ======================================================================
    // port role register fields, as seen by the decoder
    typedef struct packed {
        logic       drp;
        logic [1:0] cc2;
        logic [1:0] cc1;
    } pcd_role_t;

    // ======================================================================
    // vbus path enables driven to the power stage
    typedef struct packed {
        logic src_en;
        logic src_hv;
        logic snk_en;
        logic det_en;
    } pcd_power_t;

    // ======================================================================
    // register access from the host serial interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcd_reg_req_t;

    typedef enum logic {
        PCD_RXF_IDLE,
        PCD_RXF_ARMED
    } pcd_rxf_state_t;

endpackage
`default_nettype wire

/* verilog/pcd_top.sv */
// Operation
// - latch vconn over-current in fault bit 1
// - sink transmit with under two bytes errors
// - fault bits clear only on written one
// - invalid connection state sets host bus error
// - wake command only wakes host interface
// - presence off, refused while sourcing or sinking
// - presence on enables vbus detection
// - sink off keeps presence detection on
// - sink on, refused while sourcing
// - source off keeps presence detection on
// - source 5v, refused while sinking
// - raised voltage needs 5v source, capability
// - connection search starts drp toggling conditionally
// - final packet: clear rx config after goodcrc
// - reserved codes do nothing
// - idle command idles host interface
// - command at 23h, resets zero, auto-clears
// - presence flag follows vbus when enabled
`timescale 1ns/1ps
`default_nettype none
`include "pcd_map.svh"

module pcd_top
    import pcd_pkg::*;
#(
    parameter int ADDR_W        = 8,
    parameter bit SRC_HV_CAPABLE = 1'b1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // register access from host serial interface
    input  wire pcd_reg_req_t reg_req,
    output logic [7:0]        reg_rdata_r,
    // analog pins, asynchronous
    input  wire logic         vconn_overcurrent_flag_pin,
    input  wire logic         vbus_above_pin,
    // same-clock status from neighbouring logic
    input  wire pcd_role_t    role,
    input  wire logic         invalid_conn_reached,
    input  wire logic         sink_tx_req,
    input  wire logic [7:0]   outgoing_byte_count,
    input  wire logic         goodcrc_sent,
    // power path and detection
    output pcd_power_t        power_r,
    output logic              bus_power_present_r,
    // connection search
    output logic              toggle_start_r,
    output logic              toggle_start_rd_r,
    // receiver control
    output logic              rx_final_armed_r,
    output logic              rx_detect_clear_r,
    // host interface power state
    output logic              host_if_idle_r,
    output logic              host_if_wake_r,
    // fault status mirror
    output logic [7:0]        fault_status_r
);

    // ======================================================================
    // elaboration checks
    if (ADDR_W != 8) begin : g_bad_addr
        $error("pcd_top: register address must be 8 bits wide");
    end

    // ======================================================================
    // pin synchronisers
    logic ocp_meta_r;
    logic ocp_sync_r;
    logic vbus_meta_r;
    logic vbus_sync_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            ocp_meta_r  <= 1'b0;
            ocp_sync_r  <= 1'b0;
            vbus_meta_r <= 1'b0;
            vbus_sync_r <= 1'b0;
        end else begin
            ocp_meta_r  <= vconn_overcurrent_flag_pin;
            ocp_sync_r  <= ocp_meta_r;
            vbus_meta_r <= vbus_above_pin;
            vbus_sync_r <= vbus_meta_r;
        end
    end

    // ======================================================================
    // command register
    logic       cmd_wr;
    logic [7:0] cmd_byte;
    logic       cmd_valid;

    assign cmd_wr = reg_req.wr && (reg_req.addr == `PCD_COMMAND_ENTRY_OFFSET);

    pcd_cmd_reg u_cmd_reg (
        .clk         (clk),
        .srst        (srst),
        .wr_stb      (cmd_wr),
        .wdata       (reg_req.wdata),
        .cmd_byte_r  (cmd_byte),
        .cmd_valid_r (cmd_valid)
    );

    // ======================================================================
    // command decode
    pcd_power_t power_nxt;
    logic       cmd_err;
    logic       search_go;
    logic       search_rd;
    logic       rxf_arm;
    logic       idle_cmd;
    logic       wake_cmd;
    logic       cc_rp_both;
    logic       cc_rd_both;

    assign cc_rp_both = (role.cc1 == `PCD_CC_RP) && (role.cc2 == `PCD_CC_RP);
    assign cc_rd_both = (role.cc1 == `PCD_CC_RD) && (role.cc2 == `PCD_CC_RD);

    always_comb begin
        power_nxt = power_r;
        cmd_err   = 1'b0;
        search_go = 1'b0;
        search_rd = 1'b0;
        rxf_arm   = 1'b0;
        idle_cmd  = 1'b0;
        wake_cmd  = 1'b0;
        if (cmd_valid) begin
            unique case (cmd_byte)
                `PCD_CMD_WAKE_HOST_IF: begin
                    wake_cmd = 1'b1;
                end
                `PCD_CMD_PRESENCE_OFF: begin
                    if (power_r.src_en || power_r.snk_en) begin
                        cmd_err = 1'b1;
                    end else begin
                        power_nxt.det_en = 1'b0;
                    end
                end
                `PCD_CMD_PRESENCE_ON: begin
                    power_nxt.det_en = 1'b1;
                end
                `PCD_CMD_SINK_OFF: begin
                    power_nxt.snk_en = 1'b0;
                end
                `PCD_CMD_SINK_ON: begin
                    if (power_r.src_en) begin
                        cmd_err = 1'b1;
                    end else begin
                        power_nxt.snk_en = 1'b1;
                        power_nxt.det_en = 1'b1;
                    end
                end
                `PCD_CMD_SOURCE_OFF: begin
                    power_nxt.src_en = 1'b0;
                    power_nxt.src_hv = 1'b0;
                end
                `PCD_CMD_SOURCE_5V: begin
                    if (power_r.snk_en) begin
                        cmd_err = 1'b1;
                    end else begin
                        power_nxt.src_en = 1'b1;
                        power_nxt.src_hv = 1'b0;
                        power_nxt.det_en = 1'b1;
                    end
                end
                `PCD_CMD_SOURCE_RAISED: begin
                    // a 5v source must already be up before stepping higher
                    if (!power_r.src_en || power_r.snk_en || !SRC_HV_CAPABLE) begin
                        cmd_err = 1'b1;
                    end else begin
                        power_nxt.src_hv = 1'b1;
                    end
                end
                `PCD_CMD_CONN_SEARCH: begin
                    // reissue restarts search even with unchanged roles
                    search_go = role.drp && (cc_rp_both || cc_rd_both);
                    search_rd = cc_rd_both;
                end
                `PCD_CMD_RX_FINAL: begin
                    rxf_arm = 1'b1;
                end
                `PCD_CMD_RESERVED_C,
                `PCD_CMD_RESERVED_D,
                `PCD_CMD_RESERVED_E: begin
                    power_nxt = power_r;
                end
                `PCD_CMD_HOST_IF_IDLE: begin
                    idle_cmd = 1'b1;
                end
                default: begin
                    power_nxt = power_r;
                end
            endcase
        end
    end

    // ======================================================================
    // power path state
    always_ff @(posedge clk) begin
        if (srst) begin
            power_r <= '0;
        end else begin
            power_r <= power_nxt;
        end
    end

    // detection gate; analog hysteresis sits ahead of the pin
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_power_present_r <= 1'b0;
        end else begin
            bus_power_present_r <= power_r.det_en && vbus_sync_r;
        end
    end

    // ======================================================================
    // connection search start
    always_ff @(posedge clk) begin
        if (srst) begin
            toggle_start_r    <= 1'b0;
            toggle_start_rd_r <= 1'b0;
        end else begin
            toggle_start_r <= search_go;
            if (search_go) begin
                toggle_start_rd_r <= search_rd;
            end
        end
    end

    // ======================================================================
    // receive final packet sequencer
    pcd_rxf_state_t rxf_state_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            rxf_state_r       <= PCD_RXF_IDLE;
            rx_detect_clear_r <= 1'b0;
        end else begin
            rx_detect_clear_r <= 1'b0;
            unique case (rxf_state_r)
                PCD_RXF_IDLE: begin
                    if (rxf_arm) begin
                        rxf_state_r <= PCD_RXF_ARMED;
                    end
                end
                PCD_RXF_ARMED: begin
                    if (goodcrc_sent) begin
                        rx_detect_clear_r <= 1'b1;
                        rxf_state_r       <= rxf_arm ? PCD_RXF_ARMED : PCD_RXF_IDLE;
                    end
                end
            endcase
        end
    end

    assign rx_final_armed_r = (rxf_state_r == PCD_RXF_ARMED);

    // ======================================================================
    // host interface idle and wake
    always_ff @(posedge clk) begin
        if (srst) begin
            host_if_idle_r <= 1'b0;
            host_if_wake_r <= 1'b0;
        end else begin
            host_if_wake_r <= wake_cmd;
            if (idle_cmd) begin
                host_if_idle_r <= 1'b1;
            end else if (wake_cmd) begin
                host_if_idle_r <= 1'b0;
            end
        end
    end

    // ======================================================================
    // fault status, write one to clear, set wins over clear
    logic       flt_wr;
    logic [7:0] flt_clr;
    logic       err_set;
    logic       tx_short;

    assign flt_wr   = reg_req.wr && (reg_req.addr == `PCD_FAULT_STATUS_OFFSET);
    assign flt_clr  = flt_wr ? reg_req.wdata : 8'h00;
    assign tx_short = sink_tx_req && (outgoing_byte_count < `PCD_TX_MIN_BYTES);
    assign err_set  = cmd_err || tx_short || invalid_conn_reached;

    always_ff @(posedge clk) begin
        if (srst) begin
            fault_status_r <= `PCD_FAULT_STATUS_RESET;
        end else begin
            fault_status_r[7] <= fault_status_r[7] && !flt_clr[7];
            fault_status_r[6:2] <= 5'h00;
            fault_status_r[1] <= ocp_sync_r || (fault_status_r[1] && !flt_clr[1]);
            fault_status_r[0] <= err_set || (fault_status_r[0] && !flt_clr[0]);
        end
    end

    // ======================================================================
    // register read
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                `PCD_FAULT_STATUS_OFFSET:  reg_rdata_r <= fault_status_r;
                `PCD_COMMAND_ENTRY_OFFSET: reg_rdata_r <= cmd_byte;
                default:                   reg_rdata_r <= 8'h00;
            endcase
        end
    end

    // ======================================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_OCP_LATCH: assert property (ocp_sync_r |=> fault_status_r[1])
        else $error("vconn over-current not latched");

    AST_OCP_HOLD: assert property (fault_status_r[1] && !flt_clr[1] |=> fault_status_r[1])
        else $error("vconn over-current flag dropped without clear");

    AST_W1C_CLEAR: assert property (
        fault_status_r[0] && flt_clr[0] && !err_set |=> !fault_status_r[0])
        else $error("host bus error not cleared by written one");

    AST_TX_SHORT: assert property (
        sink_tx_req && outgoing_byte_count < 8'h02 |=> fault_status_r[0])
        else $error("short sink transmit did not flag error");

    AST_INVALID: assert property (invalid_conn_reached |=> fault_status_r[0])
        else $error("invalid connection did not flag error");

    AST_CMD_WRITE: assert property (
        cmd_wr ##1 !cmd_wr |=> cmd_byte == 8'h00)
        else $error("command register did not auto-clear");

    AST_WAKE_ONLY: assert property (
        cmd_valid && cmd_byte == 8'h11 |=> $stable(power_r) && host_if_wake_r && !host_if_idle_r)
        else $error("wake command changed power state");

    AST_DET_OFF_REJ: assert property (
        cmd_valid && cmd_byte == 8'h22 && (power_r.src_en || power_r.snk_en)
        |=> $stable(power_r.det_en) && fault_status_r[0])
        else $error("presence off not refused while powered");

    AST_SINK_ON: assert property (
        cmd_valid && cmd_byte == 8'h55 && !power_r.src_en |=> power_r.snk_en && power_r.det_en)
        else $error("sink on did not enable sink and detection");

    AST_SRC_5V_REJ: assert property (
        cmd_valid && cmd_byte == 8'h77 && power_r.snk_en |=> !power_r.src_en && fault_status_r[0])
        else $error("source 5v not refused while sinking");

    AST_RAISED: assert property (
        cmd_valid && cmd_byte == 8'h88 && !power_r.src_en |=> !power_r.src_hv && fault_status_r[0])
        else $error("raised voltage accepted without 5v source");

    AST_SEARCH_DRP: assert property (
        cmd_valid && cmd_byte == 8'h99 && !role.drp |=> !toggle_start_r)
        else $error("toggling started without drp");

    AST_RX_FINAL: assert property (
        cmd_valid && cmd_byte == 8'hAA ##1 goodcrc_sent |=> rx_detect_clear_r ##1 !rx_detect_clear_r)
        else $error("receive config not cleared after goodcrc");

    AST_RESERVED: assert property (
        cmd_valid && cmd_byte == 8'hCC |=> $stable(power_r) && !toggle_start_r)
        else $error("reserved code acted");

    AST_VBUS_FLAG: assert property (!power_r.det_en |=> !bus_power_present_r)
        else $error("presence flag high with detection off");

    COV_SINK_ON: cover property (cmd_valid && cmd_byte == 8'h55 ##1 power_r.snk_en);
    COV_RAISED_OK: cover property (cmd_valid && cmd_byte == 8'h88 ##1 power_r.src_hv);
    COV_SEARCH: cover property (toggle_start_r && toggle_start_rd_r);
    COV_RX_CLEAR: cover property (rx_detect_clear_r);

endmodule
`default_nettype wire
